// ---- inc/ccf_map.svh ----
/*
 * Register offsets, field positions, reset values and timing counts
 * of the condition flag and clock pulse block.
 * Assumes byte addressing on a 32-bit APB with word-aligned registers.
 */
`ifndef CCF_MAP_SVH
`define CCF_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CCF_OFS_COND      12'h000
`define CCF_OFS_PULSE     12'h004
`define CCF_OFS_IRQ_STAT  12'h008
`define CCF_OFS_IRQ_CLR   12'h00C
`define CCF_OFS_IRQ_EN    12'h010

// ----------------------------------------------------------------
// Condition word bit positions
// ----------------------------------------------------------------
`define CCF_BIT_IE    0
`define CCF_BIT_IAE   1
`define CCF_BIT_CO    2
`define CCF_BIT_GT    3
`define CCF_BIT_EQ    4
`define CCF_BIT_LT    5
`define CCF_BIT_N     6
`define CCF_BIT_OV    7
`define CCF_BIT_UN    8
`define CCF_BIT_GE    9
`define CCF_BIT_NE    10
`define CCF_BIT_LE    11
`define CCF_BIT_ONE   12
`define CCF_BIT_ZERO  13
`define CCF_COND_W    14

// ----------------------------------------------------------------
// Interrupt status bit positions and reset values
// ----------------------------------------------------------------
`define CCF_IRQ_IE    0
`define CCF_IRQ_IAE   1
`define CCF_IRQ_OV    2
`define CCF_IRQ_UN    3
`define CCF_IRQ_SEC   4
`define CCF_IRQ_W     5
`define CCF_IRQ_EN_RST 5'h00

// ----------------------------------------------------------------
// Timing: clock period, base tick and pulse half periods
// ----------------------------------------------------------------
`define CCF_CLK_PERIOD_NS 8
`define CCF_TICK_MS       10
`define CCF_TICK_CYCLES   ((`CCF_TICK_MS * 1000000) / `CCF_CLK_PERIOD_NS)
`define CCF_HALF_MS_20MS  10
`define CCF_HALF_MS_100MS 50
`define CCF_HALF_MS_200MS 100
`define CCF_HALF_MS_1S    500
`define CCF_HALF_MS_1MIN  30000
`define CCF_PULSE_N       5

`endif

// ---- inc/ccf_pkg.sv ----
/*
 * Types shared by the condition flag and clock pulse block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package ccf_pkg;

    // Class of the instruction that has just completed
    typedef enum logic [2:0] {
        CCF_OP_NONE,
        CCF_OP_ARITH,
        CCF_OP_SHIFT,
        CCF_OP_CMP,
        CCF_OP_RANGE
    } ccf_op_type;

endpackage
`default_nettype wire

// ---- rtl/ccf_flags.sv ----
/*
 * Condition code flags and free-running clock pulse bits, readable
 * over an APB slave, with a sticky interrupt status register.
 * Assumes the execution unit and the APB master share core_clk, and
 * that the execution unit reports each completed instruction with a
 * one-cycle ex_done pulse carrying its operands and class.
 */
// Contract
// - Processing error sets instruction error flag
// - Illegal access flag held within cycle, task
// - Carry on carry, borrow or shift-out
// - Greater-than on compare or above range
// - Equals on identical compare or zero
// - Less-than on compare or below range
// - Negative when result MSB is one
// - Overflow when result exceeds positive range
// - Underflow when result falls below range
// - Provide greater-equal, not-equal, less-equal bits
// - One bit always one, one always zero
// - 20 ms pulse, 10 ms high/low
// - 100 ms pulse, 50 ms high/low
// - 200 ms pulse, 100 ms high/low
// - One second pulse, half second phases
// - One minute pulse, thirty second phases
// - Flag area read-only, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "ccf_map.svh"

module ccf_flags
    import ccf_pkg::*;
#(
    parameter int unsigned DATA_W      = 16,                // Operand width
    parameter int unsigned TICK_CYCLES = `CCF_TICK_CYCLES   // Base tick length
) (
    input  wire logic              core_clk,           // System clock
    input  wire logic              arst_n,             // Async reset, low
    // Execution unit report
    input  wire logic              ex_done,            // Instruction completed
    input  wire ccf_op_type        ex_op,              // Instruction class
    input  wire logic              ex_sub,             // Arith: subtract
    input  wire logic              ex_shl,             // Shift: left
    input  wire logic              ex_signed,          // Compare signed
    input  wire logic [DATA_W-1:0] ex_a,               // First operand
    input  wire logic [DATA_W-1:0] ex_b,               // Second operand / low
    input  wire logic [DATA_W-1:0] ex_c,               // Range high limit
    input  wire logic              ex_err,             // Processing error
    input  wire logic              ex_acc_err,         // Illegal area access
    input  wire logic              cycle_start,        // New program cycle
    input  wire logic              task_switch,        // Task changes
    // APB slave
    input  wire logic              psel,               // Select
    input  wire logic              penable,            // Access phase
    input  wire logic              pwrite,             // Write
    input  wire logic [11:0]       paddr,              // Byte address
    input  wire logic [31:0]       pwdata,             // Write data
    output logic [31:0]            prdata,             // Read data
    output logic                   pready,             // Ready
    output logic                   pslverr,            // Unmapped address
    // Flags
    output logic                   instr_error_flag,   // Error end
    output logic                   illegal_access_flag,// Forbidden area hit
    output logic                   carry_flag,         // Carry or borrow
    output logic                   gt_flag,            // Greater than
    output logic                   eq_flag,            // Equals
    output logic                   lt_flag,            // Less than
    output logic                   neg_flag,           // Negative
    output logic                   overflow_flag,      // Overflow
    output logic                   underflow_flag,     // Underflow
    output logic                   ge_flag,            // Greater or equal
    output logic                   ne_flag,            // Not equal
    output logic                   le_flag,            // Less or equal
    output logic                   const_one_flag,     // Always one
    output logic                   const_zero_flag,    // Always zero
    output logic [4:0]             pulse,              // 20ms,100ms,200ms,1s,1min
    output logic                   irq                 // Interrupt level
);

    // ------------------------------------------------------------
    // Constants and helpers
    // ------------------------------------------------------------
    localparam int unsigned TICK_W = $clog2(TICK_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // Half period of pulse idx in base ticks
    function automatic logic [11:0] half_ticks(input int idx);
        int ms;
        ms = `CCF_HALF_MS_20MS;
        unique case (idx)
            0: ms = `CCF_HALF_MS_20MS;
            1: ms = `CCF_HALF_MS_100MS;
            2: ms = `CCF_HALF_MS_200MS;
            3: ms = `CCF_HALF_MS_1S;
            default: ms = `CCF_HALF_MS_1MIN;
        endcase
        return 12'(ms / `CCF_TICK_MS);
    endfunction

    // Three-way compare {gt, eq, lt}, signed or unsigned
    function automatic logic [2:0] cmp3(input logic [DATA_W-1:0] x,
                                        input logic [DATA_W-1:0] y,
                                        input logic sgn);
        logic gt;
        gt = sgn ? ($signed(x) > $signed(y)) : (x > y);
        return {gt, x == y, !gt && (x != y)};
    endfunction

    // ------------------------------------------------------------
    // Result arithmetic
    // ------------------------------------------------------------
    logic [DATA_W:0]   sum_w;
    logic [DATA_W-1:0] res_w;
    logic              a_msb;
    logic              b_msb;
    logic              ov_w;
    logic              un_w;
    logic [DATA_W-1:0] shr_w;
    logic              shc_w;
    logic [2:0]        cmp_w;
    logic [2:0]        lo_w;
    logic [2:0]        hi_w;

    // Add or subtract with carry or borrow out
    always_comb begin
        if (ex_sub) begin
            sum_w = {1'b0, ex_a} - {1'b0, ex_b};
        end else begin
            sum_w = {1'b0, ex_a} + {1'b0, ex_b};
        end
        res_w = sum_w[DATA_W-1:0];
        a_msb = ex_a[DATA_W-1];
        b_msb = ex_b[DATA_W-1];
        if (ex_sub) begin
            ov_w = !a_msb && b_msb && res_w[DATA_W-1];
            un_w = a_msb && !b_msb && !res_w[DATA_W-1];
        end else begin
            ov_w = !a_msb && !b_msb && res_w[DATA_W-1];
            un_w = a_msb && b_msb && !res_w[DATA_W-1];
        end
    end

    // One-place shift with the bit leaving into carry
    always_comb begin
        if (ex_shl) begin
            shr_w = {ex_a[DATA_W-2:0], 1'b0};
            shc_w = ex_a[DATA_W-1];
        end else begin
            shr_w = {1'b0, ex_a[DATA_W-1:1]};
            shc_w = ex_a[0];
        end
    end

    // Comparisons; range check tests a against [b, c]
    assign cmp_w = cmp3(ex_a, ex_b, ex_signed);
    assign lo_w  = cmp3(ex_a, ex_b, ex_signed);
    assign hi_w  = cmp3(ex_a, ex_c, ex_signed);

    // ------------------------------------------------------------
    // Condition flags
    // ------------------------------------------------------------
    logic ie_r;
    logic iae_r;
    logic co_r, co_nxt;
    logic gt_r, gt_nxt;
    logic eq_r, eq_nxt;
    logic lt_r, lt_nxt;
    logic n_r, n_nxt;
    logic ov_r, ov_nxt;
    logic un_r, un_nxt;
    logic ge_r;
    logic ne_r;
    logic le_r;
    logic one_r;
    logic zero_r;

    // Next values; unaffected flags keep their state
    always_comb begin
        co_nxt = co_r;
        gt_nxt = gt_r;
        eq_nxt = eq_r;
        lt_nxt = lt_r;
        n_nxt  = n_r;
        ov_nxt = ov_r;
        un_nxt = un_r;
        if (ex_done) begin
            unique case (ex_op)
                CCF_OP_ARITH: begin
                    co_nxt = sum_w[DATA_W];
                    eq_nxt = (res_w == '0);
                    n_nxt  = res_w[DATA_W-1];
                    ov_nxt = ov_w;
                    un_nxt = un_w;
                end
                CCF_OP_SHIFT: begin
                    co_nxt = shc_w;
                    eq_nxt = (shr_w == '0);
                    n_nxt  = shr_w[DATA_W-1];
                end
                CCF_OP_CMP: begin
                    gt_nxt = cmp_w[2];
                    eq_nxt = cmp_w[1];
                    lt_nxt = cmp_w[0];
                end
                CCF_OP_RANGE: begin
                    gt_nxt = hi_w[2];
                    lt_nxt = lo_w[0];
                    eq_nxt = !hi_w[2] && !lo_w[0];
                end
                CCF_OP_NONE: begin
                    co_nxt = co_r;
                end
            endcase
        end
    end

    // Result flags register on instruction completion
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            co_r <= 1'b0;
            gt_r <= 1'b0;
            eq_r <= 1'b0;
            lt_r <= 1'b0;
            n_r  <= 1'b0;
            ov_r <= 1'b0;
            un_r <= 1'b0;
            ge_r <= 1'b0;
            ne_r <= 1'b1;
            le_r <= 1'b0;
        end else begin
            co_r <= co_nxt;
            gt_r <= gt_nxt;
            eq_r <= eq_nxt;
            lt_r <= lt_nxt;
            n_r  <= n_nxt;
            ov_r <= ov_nxt;
            un_r <= un_nxt;
            ge_r <= gt_nxt || eq_nxt;
            ne_r <= !eq_nxt;
            le_r <= lt_nxt || eq_nxt;
        end
    end

    // Error flag follows each completed instruction
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ie_r <= 1'b0;
        end else if (ex_done) begin
            ie_r <= ex_err;
        end
    end

    // Access error lives until the cycle or task ends; set wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            iae_r <= 1'b0;
        end else if (ex_acc_err) begin
            iae_r <= 1'b1;
        end else if (cycle_start || task_switch) begin
            iae_r <= 1'b0;
        end
    end

    // Constant bits
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            one_r  <= 1'b1;
            zero_r <= 1'b0;
        end else begin
            one_r  <= 1'b1;
            zero_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Clock pulses
    // ------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt_r;
    logic              tick_r;
    logic [11:0]       pcnt_r [`CCF_PULSE_N];
    logic [4:0]        pulse_r;

    // Common base tick divided from the system clock
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r     <= 1'b0;
        end
    end

    // Each pulse toggles after its half period, starting low
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `CCF_PULSE_N; i++) begin
                pcnt_r[i] <= 12'h000;
            end
            pulse_r <= 5'h00;
        end else if (tick_r) begin
            for (int i = 0; i < `CCF_PULSE_N; i++) begin
                if (pcnt_r[i] == half_ticks(i) - 12'h001) begin
                    pcnt_r[i]  <= 12'h000;
                    pulse_r[i] <= !pulse_r[i];
                end else begin
                    pcnt_r[i] <= pcnt_r[i] + 12'h001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [`CCF_IRQ_W-1:0] irq_stat_r;
    logic [`CCF_IRQ_W-1:0] irq_en_r;
    logic [`CCF_IRQ_W-1:0] irq_ev;
    logic [`CCF_IRQ_W-1:0] irq_clr;
    logic                  irq_r;
    logic                  wr_acc;
    logic                  sec_rise;

    assign sec_rise = tick_r && (pcnt_r[3] == half_ticks(3) - 12'h001) && !pulse_r[3];

    // Events that latch into the status register
    always_comb begin
        irq_ev = '0;
        irq_ev[`CCF_IRQ_IE]  = ex_done && ex_err;
        irq_ev[`CCF_IRQ_IAE] = ex_acc_err;
        irq_ev[`CCF_IRQ_OV]  = ex_done && (ex_op == CCF_OP_ARITH) && ov_w;
        irq_ev[`CCF_IRQ_UN]  = ex_done && (ex_op == CCF_OP_ARITH) && un_w;
        irq_ev[`CCF_IRQ_SEC] = sec_rise;
    end

    assign irq_clr = (wr_acc && paddr == `CCF_OFS_IRQ_CLR) ? pwdata[`CCF_IRQ_W-1:0] : '0;

    // Sticky status; a new event wins over a clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
        end
    end

    // Enable register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_en_r <= `CCF_IRQ_EN_RST;
        end else if (wr_acc && paddr == `CCF_OFS_IRQ_EN) begin
            irq_en_r <= pwdata[`CCF_IRQ_W-1:0];
        end
    end

    // Interrupt level, registered
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_en_r);
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic [31:0] rd_w;
    logic        hit_w;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    assign wr_acc = psel && penable && pready_r && pwrite;

    // Read mux; writes to the flag and pulse words are dropped
    always_comb begin
        rd_w  = 32'h0000_0000;
        hit_w = 1'b1;
        unique case (paddr)
            `CCF_OFS_COND: begin
                rd_w[`CCF_BIT_IE]   = ie_r;
                rd_w[`CCF_BIT_IAE]  = iae_r;
                rd_w[`CCF_BIT_CO]   = co_r;
                rd_w[`CCF_BIT_GT]   = gt_r;
                rd_w[`CCF_BIT_EQ]   = eq_r;
                rd_w[`CCF_BIT_LT]   = lt_r;
                rd_w[`CCF_BIT_N]    = n_r;
                rd_w[`CCF_BIT_OV]   = ov_r;
                rd_w[`CCF_BIT_UN]   = un_r;
                rd_w[`CCF_BIT_GE]   = ge_r;
                rd_w[`CCF_BIT_NE]   = ne_r;
                rd_w[`CCF_BIT_LE]   = le_r;
                rd_w[`CCF_BIT_ONE]  = one_r;
                rd_w[`CCF_BIT_ZERO] = zero_r;
            end
            `CCF_OFS_PULSE:    rd_w[4:0] = pulse_r;
            `CCF_OFS_IRQ_STAT: rd_w[`CCF_IRQ_W-1:0] = irq_stat_r;
            `CCF_OFS_IRQ_CLR:  rd_w = 32'h0000_0000;
            `CCF_OFS_IRQ_EN:   rd_w[`CCF_IRQ_W-1:0] = irq_en_r;
            default:           hit_w = 1'b0;
        endcase
    end

    // Answer one cycle after setup; ready falls after the access
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (psel && !penable && !pready_r) begin
            pready_r  <= 1'b1;
            pslverr_r <= !hit_w;
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_w;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata              = prdata_r;
    assign pready              = pready_r;
    assign pslverr             = pslverr_r;
    assign instr_error_flag    = ie_r;
    assign illegal_access_flag = iae_r;
    assign carry_flag          = co_r;
    assign gt_flag             = gt_r;
    assign eq_flag             = eq_r;
    assign lt_flag             = lt_r;
    assign neg_flag            = n_r;
    assign overflow_flag       = ov_r;
    assign underflow_flag      = un_r;
    assign ge_flag             = ge_r;
    assign ne_flag             = ne_r;
    assign le_flag             = le_r;
    assign const_one_flag      = one_r;
    assign const_zero_flag     = zero_r;
    assign pulse               = pulse_r;
    assign irq                 = irq_r;

endmodule

`default_nettype wire

// ---- tb/ccf_flags_monitor.sv ----
/* Port checker for ccf_flags.
   Assumes one clock domain; bound to every instance below. */
`timescale 1ns/1ps
`default_nettype none
module ccf_flags_monitor
    import ccf_pkg::*;
#(
    parameter int unsigned DATA_W      = 16, // Operand width
    parameter int unsigned TICK_CYCLES = 10  // Base tick length
) (
    input wire logic core_clk, arst_n, ex_done, ex_sub, ex_err, ex_acc_err, // Control
    input wire ccf_op_type ex_op,                                           // Class
    input wire logic [DATA_W-1:0] ex_a, ex_b,                               // Operands
    input wire logic cycle_start, task_switch, instr_error_flag, illegal_access_flag, // Events
    input wire logic carry_flag, gt_flag, eq_flag, lt_flag, neg_flag, overflow_flag,  // Flags
    input wire logic underflow_flag, ge_flag, ne_flag, le_flag, const_one_flag, const_zero_flag,
    input wire logic [4:0] pulse                                            // Pulse bits
);
    logic [DATA_W-1:0] res;
    logic [31:0]       cnt_r;
    logic              seen_r;
    // Arithmetic result the flags should reflect
    assign res = ex_sub ? ex_a - ex_b : ex_a + ex_b;
    // Cycles since the 20 ms bit last changed
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 32'h0;
            seen_r <= 1'h0;
        end else if ($changed(pulse[0])) begin
            cnt_r <= 32'h0;
            seen_r <= 1'h1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_const; const_one_flag && !const_zero_flag; endproperty
    property p_derived;
        ge_flag == (gt_flag || eq_flag) && le_flag == (lt_flag || eq_flag) && ne_flag == !eq_flag;
    endproperty
    property p_err; ex_done |=> instr_error_flag == $past(ex_err); endproperty
    property p_acc_set; ex_acc_err |=> illegal_access_flag; endproperty
    property p_acc_clr; (cycle_start || task_switch) && !ex_acc_err |=> !illegal_access_flag;
    endproperty
    property p_hold;
        !ex_done |=> $stable({instr_error_flag, carry_flag, gt_flag, eq_flag, lt_flag,
                              neg_flag, overflow_flag, underflow_flag});
    endproperty
    property p_arith;
        ex_done && ex_op == CCF_OP_ARITH |=>
            neg_flag == $past(res[DATA_W-1]) && eq_flag == ($past(res) == '0);
    endproperty
    property p_pulse; $changed(pulse[0]) && seen_r |-> cnt_r == TICK_CYCLES - 1; endproperty
    a_const:   assert property (p_const)   else $error("constant bits wrong");
    a_derived: assert property (p_derived) else $error("derived compare bits wrong");
    a_err:     assert property (p_err)     else $error("error flag wrong");
    a_acc_set: assert property (p_acc_set) else $error("access flag not set");
    a_acc_clr: assert property (p_acc_clr) else $error("access flag not cleared");
    a_hold:    assert property (p_hold)    else $error("flags moved idle");
    a_arith:   assert property (p_arith)   else $error("result flags wrong");
    a_pulse:   assert property (p_pulse)   else $error("20 ms half wrong");
    c_shift: cover property (ex_done && ex_op == CCF_OP_SHIFT);
    c_sec:   cover property ($rose(pulse[3]));
    c_acc:   cover property (ex_acc_err ##2 cycle_start);
endmodule
bind ccf_flags ccf_flags_monitor #(.DATA_W(DATA_W), .TICK_CYCLES(TICK_CYCLES)) ccf_flags_monitor_i (
    .core_clk, .arst_n, .ex_done, .ex_sub, .ex_err, .ex_acc_err, .ex_op, .ex_a, .ex_b,
    .cycle_start, .task_switch, .instr_error_flag, .illegal_access_flag, .carry_flag,
    .gt_flag, .eq_flag, .lt_flag, .neg_flag, .overflow_flag, .underflow_flag, .ge_flag,
    .ne_flag, .le_flag, .const_one_flag, .const_zero_flag, .pulse);
`default_nettype wire

// ---- tb/ccf_flags_bench.sv ----
/* Self-checking bench for ccf_flags.
   Assumes a shortened base tick of 10 cycles and zero-wait APB. */
`timescale 1ns/1ps
`default_nettype none
module ccf_flags_bench
    import ccf_pkg::*;
;
    typedef struct { ccf_op_type op; logic [3:0] f; logic [15:0] a, b; logic [6:0] m, v; }
        ccf_row_type;
    logic core_clk = 1'h0, arst_n = 1'h0, ex_done = 1'h0, ex_sub = 1'h0, ex_shl = 1'h0;
    logic ex_signed = 1'h0, ex_err = 1'h0, ex_acc_err = 1'h0, cycle_start = 1'h0;
    logic task_switch = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic co, gt, eq, lt, ng, ov, un, ge, ne, le, ie, ae, one, zer, irq, se;
    ccf_op_type ex_op = CCF_OP_NONE;
    logic [15:0] ex_a = 16'h0, ex_b = 16'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0]  pulse;
    logic [6:0]  e = 7'h0;
    int n_errors = 0, n_checks = 0, n;
    // Rows: class, {sub,shl,signed,err}, a, b, touched flags, values {co,gt,eq,lt,n,ov,un}
    ccf_row_type rows [13] = '{
        '{CCF_OP_ARITH, 4'h0, 16'h7FFF, 16'h1, 7'h57, 7'h06}, '{CCF_OP_ARITH, 4'h0, 16'hFFFF, 16'h1, 7'h57, 7'h50},
        '{CCF_OP_ARITH, 4'h8, 16'h8000, 16'h1, 7'h57, 7'h01}, '{CCF_OP_ARITH, 4'h8, 16'h0, 16'h1, 7'h57, 7'h44},
        '{CCF_OP_SHIFT, 4'h4, 16'h8001, 16'h0, 7'h54, 7'h40}, '{CCF_OP_SHIFT, 4'h0, 16'h1, 16'h0, 7'h54, 7'h50},
        '{CCF_OP_CMP, 4'h0, 16'h5, 16'h3, 7'h38, 7'h20}, '{CCF_OP_CMP, 4'h2, 16'hFFFF, 16'h1, 7'h38, 7'h08},
        '{CCF_OP_CMP, 4'h0, 16'h4, 16'h4, 7'h38, 7'h10}, '{CCF_OP_RANGE, 4'h0, 16'h5, 16'h2, 7'h38, 7'h10},
        '{CCF_OP_RANGE, 4'h0, 16'h9, 16'h2, 7'h38, 7'h20}, '{CCF_OP_RANGE, 4'h0, 16'h1, 16'h2, 7'h38, 7'h08},
        '{CCF_OP_NONE, 4'h1, 16'h0, 16'h0, 7'h00, 7'h00}};
    ccf_flags #(.DATA_W(16), .TICK_CYCLES(10)) ccf_flags_i (
        .core_clk, .arst_n, .ex_done, .ex_op, .ex_sub, .ex_shl, .ex_signed, .ex_a, .ex_b,
        .ex_c(16'h0008), .ex_err, .ex_acc_err, .cycle_start, .task_switch, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_error_flag(ie),
        .illegal_access_flag(ae), .carry_flag(co), .gt_flag(gt), .eq_flag(eq), .lt_flag(lt),
        .neg_flag(ng), .overflow_flag(ov), .underflow_flag(un), .ge_flag(ge), .ne_flag(ne),
        .le_flag(le), .const_one_flag(one), .const_zero_flag(zer), .pulse, .irq);
    // Clock of 8 ns
    initial forever #4 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, s, x);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, ad, wd};
        @(posedge core_clk);
        penable <= 1'h1;
        do @(posedge core_clk); while (pready !== 1'h1);
        rd = prdata;
        se = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic exec(input ccf_row_type r);
        @(posedge core_clk);
        {ex_done, ex_op, ex_sub, ex_shl, ex_signed, ex_err, ex_a, ex_b} <= {1'h1, r.op, r.f, r.a, r.b};
        @(posedge core_clk);
        ex_done <= 1'h0;
        @(negedge core_clk);
        e = (e & ~r.m) | (r.v & r.m);
        chk({co, gt, eq, lt, ng, ov, un}, e);
        chk({ge, ne, le}, {e[5] | e[4], !e[4], e[3] | e[4]});
        chk(ie, r.f[0]);
    endtask
    // Watchdog against a hung wait
    initial begin
        #(8 * 70000);
        n_errors++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'h1;
        @(negedge core_clk);
        chk(pulse, 5'h00);
        chk({one, zer, ne}, 3'h5);
        foreach (rows[i]) exec(rows[i]);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk) ex_acc_err <= 1'h1;
            @(posedge core_clk) ex_acc_err <= 1'h0;
            @(negedge core_clk) chk(ae, 1'h1);
            @(posedge core_clk) {cycle_start, task_switch} <= i ? 2'h1 : 2'h2;
            @(posedge core_clk) {cycle_start, task_switch} <= 2'h0;
            @(negedge core_clk) chk(ae, 1'h0);
        end
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, {18'h0, 2'h1, e[3] | e[4], !e[4], e[5] | e[4], e[0], e[1], e[2], e[3], e[4], e[5], e[6], 2'h1});
        apb(1'h1, 12'h000, 32'hFFFFFFFF);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd[13:0], {2'h1, e[3] | e[4], !e[4], e[5] | e[4], e[0], e[1], e[2], e[3], e[4], e[5], e[6], 2'h1});
        apb(1'h0, 12'h0FC, 32'h0);
        chk(se, 1'h1);
        apb(1'h1, 12'h010, 32'h4);
        exec(rows[0]);
        repeat (2) @(negedge core_clk);
        chk(irq, 1'h1);
        apb(1'h0, 12'h008, 32'h0);
        chk(rd & 32'h4, 32'h4);
        for (int i = 0; i < 3; i++) begin
            apb(1'h1, i == 2 ? 12'h00C : 12'h010, i == 0 ? 32'h0 : 32'h4);
            repeat (2) @(negedge core_clk);
            chk(irq, i == 1);
        end
        for (int i = 0; i < 5; i++) begin
            logic p;
            p = pulse[i];
            do @(posedge core_clk); while (pulse[i] === p);
            n = 0;
            p = pulse[i];
            do begin
                @(posedge core_clk);
                n++;
            end while (pulse[i] === p);
            chk(n, (i == 0 ? 1 : i == 1 ? 5 : i == 2 ? 10 : i == 3 ? 50 : 3000) * 10);
        end
        chk(pulse[4], 1'h0);
        conclude();
    end
endmodule
`default_nettype wire
